// [nvh_regs.vh]
`ifndef NVH_REGS_VH
`define NVH_REGS_VH
// array geometry
`define NVH_ADDR_W 13
`define NVH_DATA_W 8
// times in ns, and derived cycle counts at 10 ns per clock
`define NVH_CLK_NS 10
`define NVH_INIT_MIN_NS 25
`define NVH_INIT_MIN_CYC ((`NVH_INIT_MIN_NS + `NVH_CLK_NS - 1) / `NVH_CLK_NS)
`define NVH_SETUP_NS 5
`define NVH_SETUP_CYC ((`NVH_SETUP_NS + `NVH_CLK_NS - 1) / `NVH_CLK_NS)
`define NVH_ACCESS_NS 45
`define NVH_ACCESS_CYC ((`NVH_ACCESS_NS + `NVH_CLK_NS - 1) / `NVH_CLK_NS)
// long waits in ns, cycle counts derived in the top module parameters
`define NVH_SAVE_NS 10000000
`define NVH_LOAD_NS 20000
`define NVH_PWRUP_NS 550000
// command codes on the user side
`define NVH_CMD_READ 2'h0
`define NVH_CMD_WRITE 2'h1
`define NVH_CMD_SAVE 2'h2
`define NVH_CMD_LOAD 2'h3
`endif

// [nvh_timer.v]
`timescale 1ns/1ps
// down counter: loaded with a count, reports done when it reaches zero
module nvh_timer (
  input wire clk,
  input wire rst,
  input wire load,
  input wire [23:0] count,
  output wire done
);
  reg [23:0] remain; // cycles still to wait

  // load wins over counting so a new wait restarts cleanly
  always @(posedge clk) begin
    if (rst) begin
      remain <= 24'h000000;
    end else if (load) begin
      remain <= count;
    end else if (remain != 24'h000000) begin
      remain <= remain - 24'h000001;
    end
  end

  assign done = (remain == 24'h000000) && !load;
endmodule

// [nvh_ctrl.v]
`timescale 1ns/1ps
`include "nvh_regs.vh"
module nvh_ctrl #(
  parameter SAVE_CYC = `NVH_SAVE_NS / `NVH_CLK_NS,
  parameter LOAD_CYC = `NVH_LOAD_NS / `NVH_CLK_NS,
  parameter PWRUP_CYC = `NVH_PWRUP_NS / `NVH_CLK_NS
) (
  input wire clk,
  input wire rst,
  input wire supply_ok,
  input wire req_valid,
  output wire req_ready,
  input wire [1:0] req_cmd,
  input wire [12:0] req_addr,
  input wire [7:0] req_wdata,
  output reg rsp_valid,
  output reg [7:0] rsp_rdata,
  output reg [12:0] addr_lines,
  output reg cs_n,
  output reg put_strobe_n,
  output reg output_on_n,
  output reg nonvolatile_select_n,
  input wire [7:0] byte_lines_in,
  output reg [7:0] byte_lines_out,
  output reg byte_lines_oe_n
);
  // one-hot states
  localparam [7:0] S_PWR = 8'h01; // waiting for supply and power-up load
  localparam [7:0] S_IDLE = 8'h02;
  localparam [7:0] S_SETUP = 8'h04; // levels applied ahead of the final edge
  localparam [7:0] S_ACT = 8'h08; // initiating combination held
  localparam [7:0] S_END = 8'h10; // final edge released
  localparam [7:0] S_WAIT = 8'h20; // self-timed transfer in progress
  localparam [7:0] S_GAP = 8'h40; // all controls high between transfers

  reg [7:0] state;
  reg [1:0] cmd; // command being served
  reg supply_seen; // supply level seen good since the last dip
  reg t_load;
  reg [23:0] t_count;
  wire t_done;
  // short waits as integers, cut to the timer's width where they are loaded
  localparam integer SETUP_C = `NVH_SETUP_CYC;
  localparam integer ACCESS_C = `NVH_ACCESS_CYC;
  localparam integer INIT_C = `NVH_INIT_MIN_CYC;

  nvh_timer u_timer (
    .clk(clk),
    .rst(rst),
    .load(t_load),
    .count(t_count),
    .done(t_done)
  );

  // every command is refused while supply is low; a dip anywhere also forces a new
  // power-up wait, since the memory reloads itself on every rise
  assign req_ready = (state == S_IDLE) && supply_ok && supply_seen;

  // sequencer; every path returns all controls high so the next start is a
  // fresh transition, which also keeps the all-low combination unreachable
  always @(posedge clk) begin
    t_load <= 1'b0;
    t_count <= 24'h000000;
    rsp_valid <= 1'b0;
    if (rst) begin
      state <= S_PWR;
      cmd <= `NVH_CMD_READ;
      supply_seen <= 1'b0;
      addr_lines <= 13'h0000;
      cs_n <= 1'b1;
      put_strobe_n <= 1'b1; // write never shown during power-up load
      output_on_n <= 1'b1;
      nonvolatile_select_n <= 1'b1;
      byte_lines_out <= 8'h00;
      byte_lines_oe_n <= 1'b1;
      rsp_rdata <= 8'h00;
    end else begin
      // a dip below the threshold in any state rearms the power-up wait
      if (!supply_ok) begin
        supply_seen <= 1'b0;
      end
      case (state)
        S_PWR: begin
          // rising supply starts the automatic load; wait it out
          if (supply_ok && !supply_seen) begin
            supply_seen <= 1'b1;
            t_load <= 1'b1;
            t_count <= PWRUP_CYC[23:0];
          end else if (supply_seen && t_done && !t_load) begin
            state <= S_IDLE;
          end
        end
        S_IDLE: begin
          if (!supply_ok || !supply_seen) begin
            // supply lost now or during a transfer: wait for a fresh load
            state <= S_PWR;
          end else if (req_valid) begin
            cmd <= req_cmd;
            addr_lines <= req_addr;
            byte_lines_out <= req_wdata;
            state <= S_SETUP;
            t_load <= 1'b1;
            t_count <= SETUP_C[23:0];
            case (req_cmd)
              `NVH_CMD_READ: begin
                cs_n <= 1'b0;
              end
              `NVH_CMD_WRITE: begin
                output_on_n <= 1'b1;
                byte_lines_oe_n <= 1'b0;
                cs_n <= 1'b0;
              end
              `NVH_CMD_SAVE: begin
                output_on_n <= 1'b1;
                nonvolatile_select_n <= 1'b0;
                cs_n <= 1'b0;
              end
              default: begin
                put_strobe_n <= 1'b1;
                byte_lines_oe_n <= 1'b1;
                cs_n <= 1'b0;
                output_on_n <= 1'b0;
              end
            endcase
          end
        end
        S_SETUP: begin
          // setup satisfied: apply the final edge
          if (t_done && !t_load) begin
            state <= S_ACT;
            t_load <= 1'b1;
            case (cmd)
              `NVH_CMD_READ: begin
                output_on_n <= 1'b0;
                t_count <= ACCESS_C[23:0];
              end
              `NVH_CMD_WRITE: begin
                put_strobe_n <= 1'b0;
                t_count <= INIT_C[23:0];
              end
              `NVH_CMD_SAVE: begin
                put_strobe_n <= 1'b0;
                t_count <= INIT_C[23:0];
              end
              default: begin
                nonvolatile_select_n <= 1'b0; // last enable falls
                t_count <= INIT_C[23:0];
              end
            endcase
          end
        end
        S_ACT: begin
          // controls and address held for the minimum time
          if (t_done && !t_load) begin
            if (cmd == `NVH_CMD_READ) begin
              rsp_rdata <= byte_lines_in;
            end
            // strobe rises first, data still driven through it
            put_strobe_n <= 1'b1;
            output_on_n <= 1'b1;
            nonvolatile_select_n <= 1'b1;
            state <= S_END;
          end
        end
        S_END: begin
          cs_n <= 1'b1;
          byte_lines_oe_n <= 1'b1; // bus released for the transfer
          t_load <= 1'b1;
          if (cmd == `NVH_CMD_SAVE) begin
            t_count <= SAVE_CYC[23:0];
          end else if (cmd == `NVH_CMD_LOAD) begin
            t_count <= LOAD_CYC[23:0];
          end else begin
            t_count <= 24'h000001;
          end
          state <= S_WAIT;
        end
        S_WAIT: begin
          // pins stay idle, nothing else is issued while the device is busy
          if (t_done && !t_load) begin
            state <= S_GAP;
          end
        end
        S_GAP: begin
          // one cycle with all controls high so the next start is a transition
          rsp_valid <= 1'b1;
          state <= S_IDLE;
        end
        default: begin
          state <= S_PWR;
        end
      endcase
    end
  end
endmodule

// [nvh_ctrl_monitor.sv]
`timescale 1ns/1ps
// pin-level checks on what the controller drives toward the memory, and on req_ready toward the host
module nvh_ctrl_monitor (
  input wire clk,
  input wire rst,
  input wire supply_ok,
  input wire req_ready,
  input wire rsp_valid,
  input wire [12:0] addr_lines,
  input wire cs_n,
  input wire put_strobe_n,
  input wire output_on_n,
  input wire nonvolatile_select_n,
  input wire byte_lines_oe_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_never_all_low: assert property (cs_n || put_strobe_n || output_on_n || nonvolatile_select_n)
    else $error("all pins low");
  a_addr_held_write: assert property (!cs_n && !put_strobe_n |-> $stable(addr_lines))
    else $error("address moved in write");
  a_oe_off_write: assert property (!put_strobe_n && nonvolatile_select_n |-> output_on_n)
    else $error("output on in write");
  a_bus_free_nv: assert property (!nonvolatile_select_n |-> byte_lines_oe_n)
    else $error("host drives in transfer");
  a_save_setup: assert property ($fell(put_strobe_n) && !nonvolatile_select_n
    |-> $past(output_on_n) && !$past(cs_n)) else $error("save setup");
  a_save_hold: assert property ($fell(put_strobe_n) && !nonvolatile_select_n
    |-> !put_strobe_n [*3]) else $error("save start too short");
  a_load_hold: assert property ($fell(nonvolatile_select_n) && put_strobe_n
    |-> !nonvolatile_select_n [*3]) else $error("load start too short");
  a_idle_at_done: assert property (rsp_valid |-> cs_n && nonvolatile_select_n)
    else $error("pins not idle");
  a_powerup_wait: assert property ($rose(supply_ok) |-> !req_ready [*8])
    else $error("ready too early");
  a_low_supply: assert property (!supply_ok |=> !req_ready)
    else $error("ready on low supply");
endmodule
bind nvh_ctrl nvh_ctrl_monitor nvh_ctrl_monitor_inst (.*);

// [nvh_dev_model.sv]
`timescale 1ns/1ps
// memory with shadow copy; transfer times shortened to clock counts
module nvh_dev_model #(
  parameter SAVE_T = 15,
  parameter LOAD_T = 8,
  parameter PWR_T = 25
) (
  input wire clk,
  input wire supply_ok,
  input wire [12:0] addr_lines,
  input wire cs_n,
  input wire put_strobe_n,
  input wire output_on_n,
  input wire nonvolatile_select_n,
  input wire [7:0] byte_lines_out,
  input wire byte_lines_oe_n,
  output wire [7:0] byte_lines_in
);
  reg [7:0] mem [0:8191]; // every address line decoded
  reg [7:0] shadow [0:8191];
  reg [19:0] busy = 0; // cycles left in a transfer
  reg saving = 0, sv_q = 0, ld_q = 0, wr_q = 0, sup_q = 0;
  reg [12:0] wa;
  reg [7:0] wd, last = 0;
  integer i;
  wire idle = busy == 0;
  wire rd = !cs_n && !output_on_n && nonvolatile_select_n && put_strobe_n && idle;
  wire wr = !cs_n && !put_strobe_n && nonvolatile_select_n;
  wire sv = !cs_n && !put_strobe_n && output_on_n && !nonvolatile_select_n;
  wire ld = !cs_n && !output_on_n && !nonvolatile_select_n && put_strobe_n;
  // released bus shows inverted last value so stale data never passes
  assign byte_lines_in = !byte_lines_oe_n ? byte_lines_out : rd ? mem[addr_lines] : ~last;
  always @(posedge clk) begin
    last <= byte_lines_in;
    sv_q <= sv;
    ld_q <= ld;
    wr_q <= wr;
    sup_q <= supply_ok;
    if (wr && idle) begin
      wa <= addr_lines;
      wd <= byte_lines_in;
    end
    if (wr_q && !wr && idle) mem[wa] <= wd;
    if (supply_ok && !sup_q) begin
      busy <= PWR_T;
      saving <= 0;
    end else if (saving && !supply_ok) busy <= 0;
    else if (idle && sv && !sv_q && supply_ok) begin
      busy <= SAVE_T;
      saving <= 1;
    end else if (idle && ld && !ld_q) begin
      busy <= LOAD_T;
      saving <= 0;
    end else if (busy == 1) begin
      for (i = 0; i < 8192; i = i + 1)
        if (saving) shadow[i] <= mem[i];
        else mem[i] <= shadow[i];
      busy <= 0;
    end else if (!idle) busy <= busy - 1; // pin commands ignored; a supply rise restarts the wait and a supply drop ends a save
  end
endmodule

// [nvh_ctrl_tb.sv]
`timescale 1ns/1ps
`include "nvh_regs.vh"
// controller against the memory model
module nvh_ctrl_tb;
  reg clk = 0, rst = 1, supply_ok = 0, req_valid = 0;
  reg [1:0] req_cmd = 0;
  reg [12:0] req_addr = 0;
  reg [7:0] req_wdata = 0;
  wire req_ready, rsp_valid, cs_n, put_strobe_n, output_on_n;
  wire nonvolatile_select_n, byte_lines_oe_n;
  wire [7:0] rsp_rdata, byte_lines_in, byte_lines_out;
  wire [12:0] addr_lines;
  integer n_mismatch = 0, comparisons = 0, k;
  initial forever #5 clk = ~clk;
  nvh_ctrl #(.SAVE_CYC(20), .LOAD_CYC(10), .PWRUP_CYC(30)) nvh_ctrl_inst (
    .clk(clk), .rst(rst), .supply_ok(supply_ok), .req_valid(req_valid),
    .req_ready(req_ready), .req_cmd(req_cmd), .req_addr(req_addr),
    .req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
    .addr_lines(addr_lines), .cs_n(cs_n), .put_strobe_n(put_strobe_n),
    .output_on_n(output_on_n), .nonvolatile_select_n(nonvolatile_select_n),
    .byte_lines_in(byte_lines_in), .byte_lines_out(byte_lines_out),
    .byte_lines_oe_n(byte_lines_oe_n)
  );
  nvh_dev_model nvh_dev_model_inst (
    .clk(clk), .supply_ok(supply_ok), .addr_lines(addr_lines), .cs_n(cs_n),
    .put_strobe_n(put_strobe_n), .output_on_n(output_on_n),
    .nonvolatile_select_n(nonvolatile_select_n), .byte_lines_out(byte_lines_out),
    .byte_lines_oe_n(byte_lines_oe_n), .byte_lines_in(byte_lines_in)
  );
  task check(input string name, input logic [7:0] seen, exp);
    comparisons = comparisons + 1;
    if (seen !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task complete_run;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // bounded waits; running out ends the run
  task wait_on(input bit ready);
    for (k = 0; k < 200 && (ready ? req_ready : rsp_valid) !== 1'b1; k = k + 1) @(negedge clk);
    if (k == 200) begin
      n_mismatch = n_mismatch + 1;
      complete_run;
    end
  endtask
  task do_req(input [1:0] cmd, input [12:0] a, input [7:0] d);
    req_cmd = cmd;
    req_addr = a;
    req_wdata = d;
    req_valid = 1;
    wait_on(1);
    @(negedge clk);
    req_valid = 0;
    wait_on(0);
  endtask
  task t_powerup;
    supply_ok = 1;
    for (k = 0; k < 200 && req_ready !== 1'b1; k = k + 1) @(negedge clk);
    check("pwrup wait", k >= 30 && k < 200, 1);
    if (k == 200) complete_run;
  endtask
  task t_rw;
    do_req(`NVH_CMD_WRITE, 13'h0000, 8'hA5);
    do_req(`NVH_CMD_WRITE, 13'h1FFF, 8'h5C);
    do_req(`NVH_CMD_READ, 13'h0000, 8'h00);
    check("rd low", rsp_rdata, 8'hA5);
    do_req(`NVH_CMD_READ, 13'h1FFF, 8'h00);
    check("rd top", rsp_rdata, 8'h5C);
  endtask
  task t_save_load;
    do_req(`NVH_CMD_SAVE, 13'h0000, 8'h00);
    do_req(`NVH_CMD_WRITE, 13'h0000, 8'h11);
    do_req(`NVH_CMD_READ, 13'h0000, 8'h00);
    check("rd new", rsp_rdata, 8'h11);
    do_req(`NVH_CMD_LOAD, 13'h0000, 8'h00);
    do_req(`NVH_CMD_READ, 13'h0000, 8'h00);
    check("rd loaded", rsp_rdata, 8'hA5);
  endtask
  task t_supply;
    // dirty the array so only the automatic reload brings the saved byte back
    do_req(`NVH_CMD_WRITE, 13'h1FFF, 8'h3C);
    do_req(`NVH_CMD_READ, 13'h1FFF, 8'h00);
    check("rd dirty", rsp_rdata, 8'h3C);
    supply_ok = 0;
    @(negedge clk);
    check("ready low", req_ready, 0);
    t_powerup;
    do_req(`NVH_CMD_READ, 13'h1FFF, 8'h00);
    check("rd pwrup", rsp_rdata, 8'h5C);
  endtask
  initial begin
    repeat (6) @(negedge clk);
    rst = 0;
    t_powerup;
    t_rw;
    t_save_load;
    t_supply;
    complete_run;
  end
endmodule
